// ### src/cmdt_pkg.sv
// package: register map, field layout, carriers for the can mask/data/timer slice
package cmdt_pkg;
  // sfr offsets
  localparam logic [7:0] OFF_TIMER_PRESCALE = 8'hA1;
  localparam logic [7:0] OFF_MAILBOX_DATA   = 8'hA3;
  localparam logic [7:0] OFF_TTC_LOW        = 8'hA4;
  localparam logic [7:0] OFF_TTC_HIGH       = 8'hA5;
  localparam logic [7:0] OFF_MSG_TIMER_LOW  = 8'hAC;
  localparam logic [7:0] OFF_MSG_TIMER_HIGH = 8'hAD;
  localparam logic [7:0] OFF_STAMP_LOW      = 8'hAE;
  localparam logic [7:0] OFF_STAMP_HIGH     = 8'hAF;
  localparam logic [7:0] OFF_ACCEPT_MASK_1  = 8'hC4;
  localparam logic [7:0] OFF_ACCEPT_MASK_2  = 8'hC5;
  localparam logic [7:0] OFF_ACCEPT_MASK_3  = 8'hC6;
  localparam logic [7:0] OFF_ACCEPT_MASK_4  = 8'hC7;

  // fields of accept_mask_4
  localparam int POS_REMOTE_REQ_FILTER = 2;
  localparam int POS_MASK4_RESERVED    = 1;
  localparam int POS_EXT_FORMAT_FILTER = 0;
  localparam int POS_MASK4_IDENT_LO    = 3;

  // reset values
  localparam logic [7:0]  RST_TIMER_DIVIDER = 8'h00;
  localparam logic [15:0] RST_RUNNING_TIMER = 16'h0000;
  localparam logic [15:0] RST_TIME_TRIGGERED = 16'h0000;
  localparam logic [7:0]  RST_READ_DATA     = 8'h00;

  // geometry
  localparam int MAILBOX_BYTES = 8;
  localparam int OBJ_COUNT     = 15;

  // received frame fields, also the tag layout of an object
  typedef struct packed {
    logic [28:0] ident;
    logic        remoteReq;
    logic        extFormat;
  } cmdt_frame_t;

  // one sfr access cycle
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } cmdt_sfr_t;
endpackage : cmdt_pkg

// ### src/cmdt_regs.sv
// module: acceptance masks, mailbox data window and can timer registers
//
// How it works
// RL1 - mask bit 0 forces identifier bit match; mask bit 1 compares it.
// RL2 - masks only filter received frames; transmit objects never hit.
// RL3 - 29 mask bits spread over four byte registers, most significant first.
// RL4 - mask register four bit 2 masks the remote request bit.
// RL5 - mask register four bit 0 masks the extension format bit.
// RL6 - software never sets mask register four bit 1; reads return zero.
// RL7 - mask registers are not reset; undefined until written.
// RL8 - data window reads and writes the byte the page selection points at.
// RL9 - writing the page selection immediately retargets the data window.
// RL10 - with auto-increment the byte pointer advances after each data access.
// RL11 - byte pointer counts modulo eight with no end stop.
// RL12 - eight-bit prescaler divides the message timer clock; resets to zero.
// RL13 - message timer is two byte registers, both zero after reset.
// RL14 - time stamp of selected object readable as two bytes; writes ignored.
// RL15 - time stamps have no reset value.
// RL16 - time-triggered timer readable as two read-only bytes, reset to zero.
// RL17 - each object holds identifier tags including the remote request tag.
// RL18 - message timer advances once per prescaled tick, wrapping to zero.
// RL19 - reading a ttc or stamp low byte freezes its high byte for a coherent pair; message timer bytes read live.
module cmdt_regs
  import cmdt_pkg::*;
#(
  parameter int OBJS = OBJ_COUNT
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  // sfr access
  input  wire cmdt_sfr_t         sfrReq,
  output logic [7:0]             sfrRdata,
  // page selection from the page register
  input  wire logic              pageLoad,
  input  wire logic [3:0]        pageObj,
  input  wire logic [2:0]        pageIdx,
  input  wire logic              pageAutoInc,
  // identifier tag load for the selected object
  input  wire logic              tagWr,
  input  wire cmdt_frame_t       tagData,
  // acceptance filtering
  input  wire logic              rxValid,
  input  wire cmdt_frame_t       rxFrame,
  input  wire logic [OBJS-1:0]   objIsRx,
  output logic [OBJS-1:0]        rxHit,
  // capture events from the protocol engine
  input  wire logic              stampCapture,
  input  wire logic [3:0]        stampObj,
  input  wire logic              ttcCapture,
  // timer view
  output logic [15:0]            runningTimer
);

  localparam int IW = $clog2(OBJS * MAILBOX_BYTES);

  // storage without reset: masks, tags, mailbox bytes, stamps
  logic [31:0]       maskMem  [0:OBJS-1];
  cmdt_frame_t       tagMem   [0:OBJS-1];
  logic [7:0]        mbxMem   [0:OBJS*MAILBOX_BYTES-1];
  logic [15:0]       stampMem [0:OBJS-1];

  logic [3:0]        objQ;
  logic [2:0]        ptrQ;
  logic [7:0]        dividerQ;
  logic [7:0]        divCntQ;
  logic [15:0]       timerQ;
  logic [15:0]       ttcQ;
  logic [7:0]        ttcHiShadowQ;
  logic [7:0]        stampHiShadowQ;
  logic [7:0]        rdataQ;

  // address decode
  wire logic         objOk      = objQ < 4'(OBJS);
  wire logic         stampObjOk = stampObj < 4'(OBJS);
  wire logic [IW-1:0] mbxIdx    = IW'({objQ, ptrQ});
  wire logic         selData    = sfrReq.addr == OFF_MAILBOX_DATA;
  wire logic         dataAcc    = selData && (sfrReq.wr || sfrReq.rd);
  wire logic         wrPresc    = sfrReq.wr && sfrReq.addr == OFF_TIMER_PRESCALE;
  wire logic         wrTimLo    = sfrReq.wr && sfrReq.addr == OFF_MSG_TIMER_LOW;
  wire logic         wrTimHi    = sfrReq.wr && sfrReq.addr == OFF_MSG_TIMER_HIGH;
  wire logic         rdTtcLo    = sfrReq.rd && sfrReq.addr == OFF_TTC_LOW;
  wire logic         rdStampLo  = sfrReq.rd && sfrReq.addr == OFF_STAMP_LOW;
  wire logic [31:0]  maskCur    = objOk ? maskMem[objQ] : 32'h0000_0000;
  wire logic [7:0]   mbxCur     = objOk ? mbxMem[mbxIdx] : 8'h00;
  wire logic [15:0]  stampCur   = objOk ? stampMem[objQ] : 16'h0000;
  wire logic         tick       = divCntQ == dividerQ;

  // mask byte write: reserved bit 1 of register four is kept at zero
  wire logic [1:0]   maskSel   = 2'(sfrReq.addr - OFF_ACCEPT_MASK_1);
  wire logic         maskWr    = sfrReq.wr && objOk && sfrReq.addr >= OFF_ACCEPT_MASK_1
                                 && sfrReq.addr <= OFF_ACCEPT_MASK_4;
  wire logic [7:0]   maskByte  = (maskSel == 2'h3)
                                 ? (sfrReq.wdata & ~(8'h01 << POS_MASK4_RESERVED)) // [RL6]
                                 : sfrReq.wdata;

  // page selection and auto-incrementing byte pointer
  wire logic [2:0]   ptrD = pageLoad ? pageIdx                               // [RL9]
                          : (dataAcc && pageAutoInc) ? 3'(ptrQ + 3'h1)       // [RL10] [RL11]
                          : ptrQ;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      objQ <= 4'h0;
      ptrQ <= 3'h0;
    end else begin
      if (pageLoad) begin
        objQ <= pageObj;
      end
      ptrQ <= ptrD;
    end
  end

  // unreset storage: masks, tags and mailbox contents stay as left
  always_ff @(posedge core_clk) begin
    if (maskWr) begin
      maskMem[objQ][8*(3-maskSel) +: 8] <= maskByte;                         // [RL3] [RL7]
    end
    if (tagWr && objOk) begin
      tagMem[objQ] <= tagData;                                               // [RL17]
    end
    if (selData && sfrReq.wr && objOk) begin
      mbxMem[mbxIdx] <= sfrReq.wdata;                                        // [RL8]
    end
    if (stampCapture && stampObjOk) begin
      stampMem[stampObj] <= timerQ;                                          // [RL15]
    end
  end

  // acceptance filter per object; transmit objects never hit
  for (genvar g = 0; g < OBJS; g++) begin : gFilter
    wire logic [28:0] idMask  = maskMem[g][31:3];                            // [RL3]
    wire logic        rtrMask = maskMem[g][POS_REMOTE_REQ_FILTER];
    wire logic        ideMask = maskMem[g][POS_EXT_FORMAT_FILTER];
    wire logic        idOk    = ~|(idMask & (rxFrame.ident ^ tagMem[g].ident));        // [RL1]
    wire logic        rtrOk   = ~(rtrMask & (rxFrame.remoteReq ^ tagMem[g].remoteReq)); // [RL4]
    wire logic        ideOk   = ~(ideMask & (rxFrame.extFormat ^ tagMem[g].extFormat)); // [RL5]
    assign rxHit[g] = rxValid && objIsRx[g] && idOk && rtrOk && ideOk;      // [RL2]
  end

  // prescaler: divider value N gives one tick every N+1 clocks
  wire logic [7:0]  divCntD = tick ? 8'h00 : 8'(divCntQ + 8'h01);            // [RL12]
  wire logic [15:0] timerInc = tick ? 16'(timerQ + 16'h0001) : timerQ;       // [RL18]
  wire logic [15:0] timerD  = wrTimLo ? {timerInc[15:8], sfrReq.wdata}
                            : wrTimHi ? {sfrReq.wdata, timerInc[7:0]}
                            : timerInc;                                      // [RL13]

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dividerQ <= RST_TIMER_DIVIDER;                                         // [RL12]
      divCntQ  <= 8'h00;
      timerQ   <= RST_RUNNING_TIMER;                                         // [RL13]
      ttcQ     <= RST_TIME_TRIGGERED;                                        // [RL16]
    end else begin
      if (wrPresc) begin
        dividerQ <= sfrReq.wdata;
      end
      divCntQ <= divCntD;
      timerQ  <= timerD;
      if (ttcCapture) begin
        ttcQ <= timerQ;
      end
    end
  end

  // high-byte shadows: a low read freezes the matching high byte
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ttcHiShadowQ   <= 8'h00;
      stampHiShadowQ <= 8'h00;
    end else begin
      if (rdTtcLo) begin
        ttcHiShadowQ <= ttcQ[15:8];                                          // [RL19]
      end
      if (rdStampLo) begin
        stampHiShadowQ <= stampCur[15:8];                                    // [RL19]
      end
    end
  end

  // read mux; stamp and ttc bytes have no write path
  logic [7:0] readVal;
  always_comb begin
    case (sfrReq.addr)
      OFF_TIMER_PRESCALE: readVal = dividerQ;
      OFF_MAILBOX_DATA:   readVal = mbxCur;                                  // [RL8]
      OFF_TTC_LOW:        readVal = ttcQ[7:0];                               // [RL16]
      OFF_TTC_HIGH:       readVal = ttcHiShadowQ;
      OFF_MSG_TIMER_LOW:  readVal = timerQ[7:0];
      OFF_MSG_TIMER_HIGH: readVal = timerQ[15:8];
      OFF_STAMP_LOW:      readVal = stampCur[7:0];                           // [RL14]
      OFF_STAMP_HIGH:     readVal = stampHiShadowQ;
      OFF_ACCEPT_MASK_1:  readVal = maskCur[31:24];
      OFF_ACCEPT_MASK_2:  readVal = maskCur[23:16];
      OFF_ACCEPT_MASK_3:  readVal = maskCur[15:8];
      OFF_ACCEPT_MASK_4:  readVal = maskCur[7:0];
      default:            readVal = 8'h00;
    endcase
  end

  // read data is held until the next read
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdataQ <= RST_READ_DATA;
    end else if (sfrReq.rd) begin
      rdataQ <= readVal;
    end
  end

  assign sfrRdata     = rdataQ;
  assign runningTimer = timerQ;

  // checks
  AST_PTR_ADVANCE: assert property (@(posedge core_clk) disable iff (!rst_b) // [RL10]
    dataAcc && pageAutoInc && !pageLoad |=> ptrQ == 3'($past(ptrQ) + 3'h1))
    else $error("byte pointer did not advance after data access");

  AST_PTR_WRAP: assert property (@(posedge core_clk) disable iff (!rst_b)    // [RL11]
    dataAcc && pageAutoInc && !pageLoad && ptrQ == 3'h7 |=> ptrQ == 3'h0)
    else $error("byte pointer did not wrap from seven to zero");

  AST_PAGE_RETARGET: assert property (@(posedge core_clk) disable iff (!rst_b) // [RL9]
    pageLoad |=> ptrQ == $past(pageIdx) && objQ == $past(pageObj))
    else $error("page selection not taken");

  AST_DATA_READ: assert property (@(posedge core_clk) disable iff (!rst_b)   // [RL8]
    sfrReq.rd && selData |=> sfrRdata == $past(mbxCur))
    else $error("data window read returned wrong byte");

  AST_TIMER_TICK: assert property (@(posedge core_clk) disable iff (!rst_b)  // [RL18]
    tick && !wrTimLo && !wrTimHi |=> timerQ == 16'($past(timerQ) + 16'h0001))
    else $error("message timer did not advance on tick");

  AST_TICK_SPACING: assert property (@(posedge core_clk) disable iff (!rst_b) // [RL12]
    tick && dividerQ != 8'h00 && !wrPresc |=> !tick)
    else $error("prescaler ticked on consecutive clocks");

  AST_TX_NO_HIT: assert property (@(posedge core_clk) disable iff (!rst_b)   // [RL2]
    (rxHit & ~objIsRx) == '0)
    else $error("transmit object hit by received frame");

  AST_MASK_OPEN: assert property (@(posedge core_clk) disable iff (!rst_b)   // [RL1]
    rxValid && objOk && objIsRx[objQ] && maskCur == 32'h0000_0000 |-> rxHit[objQ])
    else $error("fully open mask did not accept frame");

  AST_RSV_ZERO: assert property (@(posedge core_clk) disable iff (!rst_b)    // [RL6]
    sfrReq.rd && sfrReq.addr == OFF_ACCEPT_MASK_4 |=> !sfrRdata[POS_MASK4_RESERVED])
    else $error("reserved mask bit read back as one");

  AST_STAMP_RO: assert property (@(posedge core_clk) disable iff (!rst_b)    // [RL14]
    sfrReq.wr && (sfrReq.addr == OFF_STAMP_LOW || sfrReq.addr == OFF_STAMP_HIGH)
    && !stampCapture && !pageLoad |=> stampCur == $past(stampCur))
    else $error("write changed a time stamp");

  AST_TTC_PAIR: assert property (@(posedge core_clk) disable iff (!rst_b)    // [RL19]
    rdTtcLo ##1 (sfrReq.rd && sfrReq.addr == OFF_TTC_HIGH)
    |=> sfrRdata == $past(ttcQ[15:8], 2))
    else $error("ttc high byte not coherent with low byte");

  AST_TIMER_WR_LO: assert property (@(posedge core_clk) disable iff (!rst_b) // [RL13]
    wrTimLo |=> timerQ[7:0] == $past(sfrReq.wdata))
    else $error("message timer low byte write not taken");

  AST_TIMER_WR_HI: assert property (@(posedge core_clk) disable iff (!rst_b) // [RL13]
    wrTimHi |=> timerQ[15:8] == $past(sfrReq.wdata))
    else $error("message timer high byte write not taken");

  AST_TIMER_HOLD: assert property (@(posedge core_clk) disable iff (!rst_b)  // [RL12]
    !tick && !wrTimLo && !wrTimHi |=> timerQ == $past(timerQ))
    else $error("message timer moved without a prescaled tick");

  AST_PRESC_WR: assert property (@(posedge core_clk) disable iff (!rst_b)    // [RL12]
    wrPresc |=> dividerQ == $past(sfrReq.wdata))
    else $error("prescaler write not taken");

  AST_PTR_HOLD: assert property (@(posedge core_clk) disable iff (!rst_b)    // [RL10]
    (!dataAcc || !pageAutoInc) && !pageLoad |=> ptrQ == $past(ptrQ))
    else $error("byte pointer moved without a counted access");

  AST_OBJ_HOLD: assert property (@(posedge core_clk) disable iff (!rst_b)    // [RL9]
    !pageLoad |=> objQ == $past(objQ))
    else $error("selected object changed without a page load");

  AST_TTC_CAPTURE: assert property (@(posedge core_clk) disable iff (!rst_b) // [RL16]
    ttcCapture |=> ttcQ == $past(timerQ))
    else $error("ttc timer did not capture the running timer");

  AST_TTC_RO: assert property (@(posedge core_clk) disable iff (!rst_b)      // [RL16]
    !ttcCapture |=> ttcQ == $past(ttcQ))
    else $error("ttc timer changed without a capture");

  AST_TTC_LOW_READ: assert property (@(posedge core_clk) disable iff (!rst_b) // [RL16]
    rdTtcLo |=> sfrRdata == $past(ttcQ[7:0]))
    else $error("ttc low byte read returned wrong value");

  AST_STAMP_CAPTURE: assert property (@(posedge core_clk) disable iff (!rst_b) // [RL14]
    stampCapture && stampObjOk && stampObj == objQ && !pageLoad |=> stampCur == $past(timerQ))
    else $error("time stamp did not capture the running timer");

  AST_STAMP_PAIR: assert property (@(posedge core_clk) disable iff (!rst_b)  // [RL19]
    rdStampLo ##1 (sfrReq.rd && sfrReq.addr == OFF_STAMP_HIGH)
    |=> sfrRdata == $past(stampCur[15:8], 2))
    else $error("stamp high byte not coherent with low byte");

  AST_IDLE_NO_HIT: assert property (@(posedge core_clk) disable iff (!rst_b) // [RL2]
    !rxValid |-> rxHit == '0)
    else $error("object hit with no received frame");

endmodule : cmdt_regs

// ### verif/cmdt_tb.sv
// testbench: sfr-driven checks of masks, mailbox window and can timer
module tb
  import cmdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic            core_clk;
  logic            rst_b;
  cmdt_sfr_t       sfrReq;
  logic [7:0]      sfrRdata;
  logic            pageLoad, pageAutoInc, tagWr, rxValid, stampCapture, ttcCapture;
  logic [3:0]      pageObj, stampObj;
  logic [2:0]      pageIdx;
  cmdt_frame_t     tagData, rxFrame;
  logic [14:0]     objIsRx, rxHit;
  logic [15:0]     runningTimer;
  int              n_fail, compares, cyc;
  logic [7:0]      rdv, rdv2, mb[8];
  logic [15:0]     v;
  logic [31:0]     mk[9];
  logic [30:0]     fl[9];
  logic            rx[9], ex[9];

  cmdt_regs i_dut (.core_clk(core_clk), .rst_b(rst_b), .sfrReq(sfrReq), .sfrRdata(sfrRdata),
    .pageLoad(pageLoad), .pageObj(pageObj), .pageIdx(pageIdx), .pageAutoInc(pageAutoInc),
    .tagWr(tagWr), .tagData(tagData), .rxValid(rxValid), .rxFrame(rxFrame), .objIsRx(objIsRx),
    .rxHit(rxHit), .stampCapture(stampCapture), .stampObj(stampObj), .ttcCapture(ttcCapture),
    .runningTimer(runningTimer));

  always #25 core_clk = ~core_clk;

  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) sfrReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk) sfrReq <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk) sfrReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk) sfrReq <= '0;
    #1 d = sfrRdata;
  endtask : rd

  // two reads on consecutive clocks, as the coherent byte pair wants them
  task automatic rd2(input logic [7:0] a, input logic [7:0] b, output logic [7:0] d, output logic [7:0] e);
    @(posedge core_clk) sfrReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk) sfrReq <= '{addr: b, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    #1 d = sfrRdata;
    @(posedge core_clk) sfrReq <= '0;
    #1 e = sfrRdata;
  endtask : rd2

  task automatic page(input logic [3:0] o, input logic [2:0] i, input logic inc);
    @(posedge core_clk) {pageLoad, pageObj, pageIdx, pageAutoInc} <= {1'b1, o, i, inc};
    @(posedge core_clk) pageLoad <= 1'b0;
  endtask : page

  task automatic final_report();
    if (n_fail == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report

  initial begin
    core_clk = 1'b0; rst_b = 1'b0; sfrReq = '0; pageLoad = 1'b0; pageObj = 4'h0; pageIdx = 3'h0;
    pageAutoInc = 1'b0; tagWr = 1'b0; tagData = '0; rxValid = 1'b0; rxFrame = '0; objIsRx = '0;
    stampCapture = 1'b0; stampObj = 4'h0; ttcCapture = 1'b0;
    repeat (4) @(posedge core_clk);
    chk("timer in reset", runningTimer, 32'h0000);
    rst_b <= 1'b1;
    rd(8'hA1, rdv); chk("prescaler reset", rdv, 32'h00);
    rd(8'hA4, rdv); chk("ttc low reset", rdv, 32'h00);
    rd(8'hA5, rdv); chk("ttc high reset", rdv, 32'h00);
    rd(8'h00, rdv); chk("unmapped read", rdv, 32'h00);
    // prescaler 0 ticks every clock, so the wrap point is exact
    wr(8'hAC, 8'hFD);
    wr(8'hAD, 8'hFF);
    #1 chk("timer after byte writes", runningTimer, 32'hFFFF);
    @(posedge core_clk) #1 chk("timer wrap", runningTimer, 32'h0000);
    wr(8'hA1, 8'h03);
    rd(8'hA1, rdv); chk("prescaler readback", rdv, 32'h03);
    v = runningTimer;
    repeat (8) @(posedge core_clk);
    #1 chk("divided count", 16'(runningTimer - v), 32'h0002);
    // nonzero high byte, so a lost shadow copy cannot pass as the reset zero
    wr(8'hAD, 8'h5C);
    // capture samples the value just before the capture edge
    @(posedge core_clk) ttcCapture <= 1'b1;
    #1 v = runningTimer;
    @(posedge core_clk) ttcCapture <= 1'b0;
    wr(8'hA4, 8'h55);
    rd(8'hA4, rdv); chk("ttc low", rdv, {24'h0, v[7:0]});
    rd(8'hA5, rdv); chk("ttc high", rdv, {24'h0, v[15:8]});
    rd2(8'hA4, 8'hA5, rdv, rdv2);
    chk("ttc low pair", rdv, {24'h0, v[7:0]});
    chk("ttc high pair", rdv2, {24'h0, v[15:8]});
    page(4'h2, 3'h0, 1'b0);
    @(posedge core_clk) {stampCapture, stampObj} <= {1'b1, 4'h2};
    #1 v = runningTimer;
    @(posedge core_clk) stampCapture <= 1'b0;
    wr(8'hAE, 8'hAA);
    wr(8'hAF, 8'hAA);
    rd(8'hAE, rdv); chk("stamp low", rdv, {24'h0, v[7:0]});
    rd(8'hAF, rdv); chk("stamp high", rdv, {24'h0, v[15:8]});
    rd2(8'hAE, 8'hAF, rdv, rdv2);
    chk("stamp low pair", rdv, {24'h0, v[7:0]});
    chk("stamp high pair", rdv2, {24'h0, v[15:8]});
    // mailbox: ten writes from byte 6 wrap the pointer past 7 twice over byte 6..7
    page(4'h1, 3'h6, 1'b1);
    for (int k = 0; k < 10; k++) begin
      wr(8'hA3, 8'hA0 + 8'(k));
      mb[(6 + k) % 8] = 8'hA0 + 8'(k);
    end
    page(4'h1, 3'h6, 1'b1);
    for (int k = 0; k < 8; k++) begin
      rd(8'hA3, rdv); chk("mailbox byte", rdv, {24'h0, mb[(6 + k) % 8]});
    end
    page(4'h3, 3'h0, 1'b0);
    wr(8'hA3, 8'h5A);
    rd(8'hA3, rdv); chk("no increment", rdv, 32'h5A);
    page(4'h1, 3'h7, 1'b0);
    rd(8'hA3, rdv); chk("retarget", rdv, {24'h0, mb[7]});
    // acceptance filter on object 1
    @(posedge core_clk) {tagWr, tagData} <= {1'b1, 29'h1234567, 1'b0, 1'b1};
    @(posedge core_clk) tagWr <= 1'b0;
    // software never writes reserved bit 1 of mask four; the last case opens every bit
    mk = '{32'hFFFFFFFD, 32'hFFFFFFFD, 32'h7FFFFFFD, 32'hFFFFFFFD, 32'hFFFFFFF9, 32'hFFFFFFFD,
           32'hFFFFFFFC, 32'hFFFFFFFD, 32'h00000000};
    fl = '{31'h0, 31'h40000000, 31'h40000000, 31'h2, 31'h2, 31'h1, 31'h1, 31'h0, 31'h7FFFFFFF};
    rx = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
    ex = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    for (int c = 0; c < 9; c++) begin
      for (int b = 0; b < 4; b++) wr(OFF_ACCEPT_MASK_1 + 8'(b), mk[c][31 - 8 * b -: 8]);
      for (int b = 0; b < 4; b++) begin
        rd(OFF_ACCEPT_MASK_1 + 8'(b), rdv); chk("mask byte", rdv, {24'h0, mk[c][31 - 8 * b -: 8] & (b == 3 ? 8'hFD : 8'hFF)});
      end
      @(posedge core_clk) {rxValid, rxFrame, objIsRx} <= {1'b1, tagData ^ fl[c], 13'h0, rx[c], 1'b0};
      @(posedge core_clk) #1 chk("filter hit", rxHit[1], ex[c]);
    end
    final_report();
  end
endmodule : tb
